// ==== logic/ptb_defines.svh ====
/*
 * Constants of the PWM time base: register offsets, field positions,
 * reset values and counts.
 * Assumes inclusion by bare name from the time base and the bench.
 */
`ifndef PTB_DEFINES_SVH
`define PTB_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define PTB_ADDR_CTRL 4'h0
`define PTB_ADDR_PERIOD 4'h1
`define PTB_ADDR_SECMP 4'h2
`define PTB_ADDR_STATUS 4'h3
`define PTB_ADDR_COUNT 4'h4
`define PTB_ADDR_DUTY0 4'h8

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define PTB_MODE_LSB 0
`define PTB_MODE_MSB 1
`define PTB_PRE_LSB 2
`define PTB_PRE_MSB 3
`define PTB_POST_LSB 4
`define PTB_POST_MSB 7
`define PTB_IDLE_BIT 13
`define PTB_ON_BIT 15

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define PTB_CTRL_RST 16'h0000
`define PTB_PERIOD_RST 16'hFFFF
`define PTB_PRE_MAX 6'h3F

`endif

// ==== logic/ptb_pkg.sv ====
/*
 * Types of the PWM time base.
 * Assumes the constants header beside it.
 */
package ptb_pkg;

    // ----------------------------------------------------------------
    // counting modes, code as held in the mode field
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PTB_FREE = 2'h0,
        PTB_SINGLE = 2'h1,
        PTB_UPDN = 2'h2,
        PTB_UPDN_DBL = 2'h3
    } ptb_mode_t;

    // ----------------------------------------------------------------
    // counter direction states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PTB_UP = 2'h1,
        PTB_DOWN = 2'h2
    } ptb_dir_t;

endpackage : ptb_pkg

// ==== logic/ptb_duty_mem.sv ====
/*
 * Small buffer memory for the software duty values.
 * Assumes one write port and one registered read port on one clock.
 */
`timescale 1ns/1ps
module ptb_duty_mem #(
    parameter int DEPTH = 4,
    parameter int AW = 2,
    parameter int DW = 16
) (
    input wire logic ref_clk_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o
);
    logic [DW-1:0] mem [DEPTH];

    // ----------------------------------------------------------------
    // storage, no reset: software loads before enabling
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule : ptb_duty_mem

// ==== logic/ptb_time_base.sv ====
/*
 * PWM time base with duty compare outputs.
 * Assumes a plain register port, synchronous inputs, one clock.
 */
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ptb_defines.svh"
module ptb_time_base #(
    parameter int NUM_GEN = 4,
    parameter int GEN_AW = 2,
    parameter int CW = 16
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic cycle_interrupt_flag_o,
    output logic event_trigger_out_o,
    output logic [NUM_GEN-1:0] high_side_out_o,
    output logic [NUM_GEN-1:0] low_side_out_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [5:0] pre_limit(input logic [1:0] code);
        unique case (code)
            2'h0: pre_limit = 6'h00;
            2'h1: pre_limit = 6'h03;
            2'h2: pre_limit = 6'h0F;
            default: pre_limit = `PTB_PRE_MAX;
        endcase
    endfunction : pre_limit

    function automatic logic is_duty_addr(input logic [3:0] a);
        is_duty_addr = (a >= `PTB_ADDR_DUTY0) &&
            (a < `PTB_ADDR_DUTY0 + 4'(NUM_GEN));
    endfunction : is_duty_addr

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0] time_base_control, next_time_base_control;
    logic [CW-1:0] period_value, next_period_value;
    logic [CW-1:0] event_compare_buf, next_event_compare_buf;
    logic [CW-1:0] event_compare_value, next_event_compare_value;
    logic [CW-1:0] count, next_count;
    ptb_pkg::ptb_dir_t dir, next_dir;
    logic [5:0] pre_cnt, next_pre_cnt;
    logic [3:0] post_cnt, next_post_cnt;
    logic flag, next_flag;
    logic evt, next_evt;
    logic [CW-1:0] duty_work [NUM_GEN];
    logic [CW-1:0] next_duty_work [NUM_GEN];
    logic [NUM_GEN-1:0] pwm_on, next_pwm_on;
    logic [15:0] next_rdata;
    logic load_busy, next_load_busy;
    logic [GEN_AW-1:0] load_idx, next_load_idx;
    logic [CW-1:0] mem_rdata;
    logic [GEN_AW-1:0] mem_raddr;
    logic load_wr;
    logic [GEN_AW-1:0] load_wr_idx;

    ptb_pkg::ptb_mode_t mode;
    logic time_base_on, tick, at_top, at_zero, reload, qual_evt;
    logic [3:0] post_sel;

    assign mode = ptb_pkg::ptb_mode_t'(time_base_control[`PTB_MODE_MSB:`PTB_MODE_LSB]);
    assign post_sel = time_base_control[`PTB_POST_MSB:`PTB_POST_LSB];
    assign time_base_on = time_base_control[`PTB_ON_BIT];

    // ----------------------------------------------------------------
    // duty buffers; read port walks generators for the reload copy
    // ----------------------------------------------------------------
    assign mem_raddr = load_busy ? load_idx : reg_addr_i[GEN_AW-1:0];

    ptb_duty_mem #(
        .DEPTH(NUM_GEN),
        .AW(GEN_AW),
        .DW(CW)
    ) ptb_duty_mem_inst (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(reg_wr_i && is_duty_addr(reg_addr_i)),
        .wr_addr_i(reg_addr_i[GEN_AW-1:0]),
        .wr_data_i(reg_wdata_i),
        .rd_addr_i(mem_raddr),
        .rd_data_o(mem_rdata)
    );

    // ----------------------------------------------------------------
    // prescaler and counter
    // ----------------------------------------------------------------
    assign tick = time_base_on && (pre_cnt == pre_limit(
        time_base_control[`PTB_PRE_MSB:`PTB_PRE_LSB]));
    assign at_top = (count == period_value);
    assign at_zero = (count == '0);

    // reload points per mode, on the tick that leaves the point
    always_comb begin
        reload = 1'b0;
        qual_evt = 1'b0;
        unique case (mode)
            ptb_pkg::PTB_FREE: begin
                reload = tick && at_top;
                qual_evt = tick && at_top;
            end
            ptb_pkg::PTB_UPDN: begin
                reload = tick && at_zero && (dir == ptb_pkg::PTB_DOWN);
                qual_evt = tick && at_zero && (dir == ptb_pkg::PTB_DOWN);
            end
            ptb_pkg::PTB_UPDN_DBL: begin
                reload = tick && (at_zero || at_top);
                qual_evt = reload;
            end
            // single-shot is not supported; the counter holds
            default: reload = 1'b0;
        endcase
    end

    always_comb begin
        next_pre_cnt = tick || !time_base_on ? 6'h00 : pre_cnt + 6'h01;
        next_count = count;
        next_dir = dir;
        if (!time_base_on) begin
            next_count = '0;
            next_dir = ptb_pkg::PTB_UP;
        end else if (tick) begin
            unique case (mode)
                ptb_pkg::PTB_FREE: begin
                    next_count = at_top ? '0 : count + 1'b1;
                    next_dir = ptb_pkg::PTB_UP;
                end
                ptb_pkg::PTB_UPDN, ptb_pkg::PTB_UPDN_DBL: begin
                    unique case (dir)
                        ptb_pkg::PTB_UP: begin
                            next_count = at_top ? count - 1'b1 : count + 1'b1;
                            if (at_top) next_dir = ptb_pkg::PTB_DOWN;
                        end
                        ptb_pkg::PTB_DOWN: begin
                            next_count = at_zero ? count + 1'b1 : count - 1'b1;
                            if (at_zero) next_dir = ptb_pkg::PTB_UP;
                        end
                    endcase
                end
                // single-shot: the counter holds
                default: next_count = count;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // cycle flag, postscaled except in double-update mode; one-cycle pulse
    // ----------------------------------------------------------------
    always_comb begin
        next_flag = 1'b0;
        next_post_cnt = post_cnt;
        if (!time_base_on) begin
            next_post_cnt = 4'h0;
        end else if (qual_evt) begin
            if (mode == ptb_pkg::PTB_UPDN_DBL) begin
                next_flag = 1'b1;
            end else if (post_cnt >= post_sel) begin
                next_flag = 1'b1;
                next_post_cnt = 4'h0;
            end else begin
                next_post_cnt = post_cnt + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers, working copies, compare outputs
    // ----------------------------------------------------------------
    always_comb begin
        next_time_base_control = time_base_control;
        next_period_value = period_value;
        next_event_compare_buf = event_compare_buf;
        next_event_compare_value = event_compare_value;
        next_load_busy = load_busy;
        next_load_idx = load_idx;
        next_rdata = 16'h0000;
        next_duty_work = duty_work;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `PTB_ADDR_CTRL: next_time_base_control = reg_wdata_i;
                `PTB_ADDR_PERIOD: next_period_value = reg_wdata_i;
                `PTB_ADDR_SECMP: next_event_compare_buf = reg_wdata_i;
                default: next_time_base_control = time_base_control;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `PTB_ADDR_CTRL: next_rdata = time_base_control;
                `PTB_ADDR_PERIOD: next_rdata = period_value;
                `PTB_ADDR_SECMP: next_rdata = event_compare_buf;
                `PTB_ADDR_STATUS: next_rdata = {14'h0000, dir == ptb_pkg::PTB_DOWN, flag};
                `PTB_ADDR_COUNT: next_rdata = count;
                default: next_rdata = 16'h0000;
            endcase
        end
        // copy walk: one generator per cycle; at divide by one the first
        // counts after a reload still compare against the old values
        if (reload) begin
            next_event_compare_value = event_compare_buf;
            next_load_busy = 1'b1;
            next_load_idx = '0;
        end else if (load_busy) begin
            next_load_idx = load_idx + 1'b1;
            next_load_busy = (load_idx != GEN_AW'(NUM_GEN - 1));
        end
        // read data trail the address by one cycle, so write at the delayed index
        if (load_wr) next_duty_work[load_wr_idx] = mem_rdata;
    end

    always_comb begin
        next_pwm_on = pwm_on;
        next_evt = tick && (count == event_compare_value);
        for (int g = 0; g < NUM_GEN; g++) begin
            if (duty_work[g] == '0) begin
                next_pwm_on[g] = 1'b0;
            end else if (duty_work[g] > period_value) begin
                next_pwm_on[g] = 1'b1;
            end else if (count == duty_work[g]) begin
                next_pwm_on[g] = 1'b0;
            end else if (at_zero) begin
                next_pwm_on[g] = 1'b1;
            end
        end
        if (!time_base_on) begin
            next_pwm_on = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            time_base_control <= `PTB_CTRL_RST;
            period_value <= `PTB_PERIOD_RST;
            event_compare_buf <= '0;
            event_compare_value <= '0;
            count <= '0;
            dir <= ptb_pkg::PTB_UP;
            pre_cnt <= 6'h00;
            post_cnt <= 4'h0;
            flag <= 1'b0;
            evt <= 1'b0;
            pwm_on <= '0;
            reg_rdata_o <= 16'h0000;
            load_busy <= 1'b0;
            load_idx <= '0;
            load_wr <= 1'b0;
            load_wr_idx <= '0;
            duty_work <= '{default: '0};
        end else begin
            time_base_control <= next_time_base_control;
            period_value <= next_period_value;
            event_compare_buf <= next_event_compare_buf;
            event_compare_value <= next_event_compare_value;
            count <= next_count;
            dir <= next_dir;
            pre_cnt <= next_pre_cnt;
            post_cnt <= next_post_cnt;
            flag <= next_flag;
            evt <= next_evt;
            pwm_on <= next_pwm_on;
            reg_rdata_o <= next_rdata;
            load_busy <= next_load_busy;
            load_idx <= next_load_idx;
            load_wr <= load_busy;
            load_wr_idx <= load_idx;
            duty_work <= next_duty_work;
        end
    end

    assign cycle_interrupt_flag_o = flag;
    assign event_trigger_out_o = evt;
    assign high_side_out_o = pwm_on;
    assign low_side_out_o = ~pwm_on;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    free_wrap_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        tick && mode == ptb_pkg::PTB_FREE && at_top |=> count == '0)
        else $error("free mode did not wrap to zero");
    updn_turn_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        tick && mode == ptb_pkg::PTB_UPDN && at_top && dir == ptb_pkg::PTB_UP
        && period_value != '0 |=> dir == ptb_pkg::PTB_DOWN)
        else $error("up/down did not turn at period");
    pre_div_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        tick && time_base_control[3:2] == 2'h1 && $stable(time_base_control)
        |=> !tick [*3])
        else $error("divide by four broken");
    dbl_flag_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        tick && time_base_on && mode == ptb_pkg::PTB_UPDN_DBL && at_zero |=> flag)
        else $error("double update flag missing");
    zero_duty_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        duty_work[0] == '0 |=> !high_side_out_o[0])
        else $error("zero duty drove output");
    over_duty_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        time_base_on && duty_work[0] > period_value |=> high_side_out_o[0])
        else $error("over-period duty not held active");
    match_off_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        time_base_on && duty_work[0] != '0 && duty_work[0] <= period_value
        && count == duty_work[0] |=> !high_side_out_o[0])
        else $error("output not cleared on match");
    secmp_load_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        reload |=> event_compare_value == $past(event_compare_buf))
        else $error("event compare not reloaded");
    post_once_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        flag && mode != ptb_pkg::PTB_UPDN_DBL |-> post_cnt == 4'h0)
        else $error("postscale counter not restarted");
    free_cov: cover property (@(posedge ref_clk_i) mode == ptb_pkg::PTB_FREE && flag);
    updn_cov: cover property (@(posedge ref_clk_i) mode == ptb_pkg::PTB_UPDN && flag);
    dbl_cov: cover property (@(posedge ref_clk_i) mode == ptb_pkg::PTB_UPDN_DBL && reload);
endmodule : ptb_time_base

// ==== sim/ptb_gate_drv_model.sv ====
/*
 * Gate driver model of the power stage: watches each high/low pair.
 * Assumes registered outputs from the time base on the same clock.
 */
`timescale 1ns/1ps
module ptb_gate_drv_model #(
    parameter int NUM_GEN = 4
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [NUM_GEN-1:0] high_side_out_i,
    input wire logic [NUM_GEN-1:0] low_side_out_i,
    output logic [15:0] fault_count_o
);
    // ------------------------------------------------------------
    // pair watch
    // ------------------------------------------------------------
    // both on would short the leg; both off is counted too, since
    // pairs are driven complementary with no dead time in this block
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            fault_count_o <= 16'h0000;
        end else if ((high_side_out_i ^ low_side_out_i) !== {NUM_GEN{1'b1}}) begin
            fault_count_o <= fault_count_o + 16'h0001;
        end
    end
endmodule : ptb_gate_drv_model

// ==== sim/test_pwm_time_base_output.sv ====
/*
 * Self-checking bench for the PWM time base and duty outputs.
 * Assumes the design files and the gate driver model compiled first.
 */
`timescale 1ns/1ps
`include "ptb_defines.svh"
module test_pwm_time_base_output;
    localparam int NG = 4;
    logic ref_clk_i;
    logic sys_rst_i;
    logic [3:0] reg_addr_i;
    logic [15:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [15:0] reg_rdata_o;
    logic flag;
    logic evt;
    logic [NG-1:0] hi;
    logic [NG-1:0] lo;
    logic [15:0] faults;
    logic rd_pend;
    logic [15:0] exp_q[$];
    logic [1:0] modes [3] = '{ptb_pkg::PTB_FREE, ptb_pkg::PTB_UPDN, ptb_pkg::PTB_UPDN_DBL};
    int err_count;
    int n_checks;
    int flags;
    int evts;
    int on_cnt [NG];
    int m;
    int pre;
    int d2;

    ptb_time_base #(.NUM_GEN(NG), .GEN_AW(2), .CW(16)) ptb_time_base_inst (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cycle_interrupt_flag_o(flag),
        .event_trigger_out_o(evt), .high_side_out_o(hi), .low_side_out_o(lo));

    ptb_gate_drv_model #(.NUM_GEN(NG)) ptb_gate_drv_model_inst (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .high_side_out_i(hi),
        .low_side_out_i(lo), .fault_count_o(faults));

    // ------------------------------------------------------------
    // clock and read monitor
    // ------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // read data stand only in the cycle after the strobe: look mid-cycle
    always @(posedge ref_clk_i) rd_pend <= reg_rd_i;
    always @(negedge ref_clk_i) begin
        if (rd_pend === 1'b1) begin
            chk("read data", exp_q.pop_front(), reg_rdata_o);
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        exp_q.push_back(e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // bounded wait; a missing pulse ends the run
    task automatic wait_flag();
        int i;
        for (i = 0; i < 20000; i++) begin
            @(posedge ref_clk_i);
            #1;
            if (flag === 1'b1) return;
        end
        err_count++;
        $display("FAIL flag wait expected 1 seen 0");
        print_verdict();
    endtask : wait_flag

    // counts pulses and on-cycles over a window of n whole cycles
    task automatic measure(input int n);
        int i;
        int g;
        flags = 0;
        evts = 0;
        on_cnt = '{default: 0};
        for (i = 0; i < n; i++) begin
            @(posedge ref_clk_i);
            #1;
            flags += int'(flag === 1'b1);
            evts += int'(evt === 1'b1);
            for (g = 0; g < NG; g++) on_cnt[g] += int'(hi[g] === 1'b1);
        end
    endtask : measure

    // flag spacing = period ticks x divide x postscale (none when double)
    task automatic run_mode(input logic [1:0] md, input logic [1:0] ps, input logic [3:0] po,
                            input logic [15:0] p);
        int per;
        per = (md == ptb_pkg::PTB_FREE) ? int'(p) + 1 :
              (md == ptb_pkg::PTB_UPDN) ? 2 * int'(p) : int'(p);
        per = per * (1 << (2 * ps));
        if (md != ptb_pkg::PTB_UPDN_DBL) per = per * (int'(po) + 1);
        wr(`PTB_ADDR_CTRL, 16'h0000);
        wr(`PTB_ADDR_PERIOD, p);
        wr(`PTB_ADDR_CTRL, {1'b1, 7'h00, po, ps, md});
        wait_flag();
        measure(2 * per);
        chk("flag count", 16'h0002, 16'(flags));
    endtask : run_mode

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        reg_addr_i = 4'h0;
        reg_wdata_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        err_count = 0;
        n_checks = 0;
        void'($urandom(32'h5D35));
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        // reset values, unmapped and write-only places
        rd(`PTB_ADDR_CTRL, `PTB_CTRL_RST);
        rd(`PTB_ADDR_PERIOD, `PTB_PERIOD_RST);
        wr(4'h5, 16'h1234);
        rd(4'h5, 16'h0000);
        wr(`PTB_ADDR_DUTY0, 16'h0123);
        rd(`PTB_ADDR_DUTY0, 16'h0000);
        wr(`PTB_ADDR_CTRL, 16'h0004);
        rd(`PTB_ADDR_CTRL, 16'h0004);
        // every continuous mode with every prescale; single-shot never set
        for (m = 0; m < 3; m++) begin
            for (pre = 0; pre < 4; pre++) begin
                run_mode(modes[m], 2'(pre), 4'($urandom % 4), 16'(2 + $urandom % 4));
            end
        end
        run_mode(ptb_pkg::PTB_FREE, 2'h1, 4'h0, 16'd3);
        // duty outputs: zero, above period, random, equal to period
        d2 = 1 + $urandom % 9;
        wr(`PTB_ADDR_CTRL, 16'h0000);
        wr(`PTB_ADDR_PERIOD, 16'd9);
        wr(`PTB_ADDR_SECMP, 16'd5);
        wr(`PTB_ADDR_DUTY0, 16'd0);
        wr(`PTB_ADDR_DUTY0 + 4'h1, 16'd40);
        wr(`PTB_ADDR_DUTY0 + 4'h2, 16'(d2));
        wr(`PTB_ADDR_DUTY0 + 4'h3, 16'd9);
        wr(`PTB_ADDR_CTRL, 16'h8000);
        wait_flag();
        wait_flag();
        measure(30);
        chk("gen0 on", 16'd0, 16'(on_cnt[0]));
        chk("gen1 on", 16'd30, 16'(on_cnt[1]));
        chk("gen2 on", 16'(3 * d2), 16'(on_cnt[2]));
        chk("gen3 on", 16'd27, 16'(on_cnt[3]));
        chk("event count", 16'd3, 16'(evts));
        // stopped base: no pulses, count cleared and read-only
        wr(`PTB_ADDR_CTRL, 16'h0000);
        measure(100);
        chk("stopped flags", 16'd0, 16'(flags));
        wr(`PTB_ADDR_COUNT, 16'h0007);
        rd(`PTB_ADDR_COUNT, 16'h0000);
        rd(`PTB_ADDR_SECMP, 16'd5);
        rd(`PTB_ADDR_STATUS, 16'h0000);
        @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("pair faults", 16'h0000, faults);
        print_verdict();
    end
endmodule : test_pwm_time_base_output
